// File: inc/purs_defines.vh
`ifndef PURS_DEFINES_VH
`define PURS_DEFINES_VH
// power-up delay period in internal rc oscillator cycles
`define PURS_DELAY_CYCLES 16'h1000
`define PURS_CNT_W 16
// oscillator settle length in main oscillator input cycles
`define PURS_SETTLE_CYCLES 16'h0400
// oscillator mode codes
`define PURS_OSC_LOW_POWER 2'h0
`define PURS_OSC_MEDIUM 2'h1
`define PURS_OSC_HIGH_SPEED 2'h2
`define PURS_OSC_RC 2'h3
`endif

// File: rtl/purs_edge.v
`timescale 1ns/10ps
`include "purs_defines.vh"
// one-cycle enable on each rising edge of a synchronised clock level
module purs_edge (
   input wire mclk_in,
   input wire reset_in,
   input wire lvl_in,
   output wire tick_out
);
   reg prev_q;
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= lvl_in;
      end
   end
   assign tick_out = lvl_in & ~prev_q;
endmodule // purs_edge

// File: rtl/purs_sequencer.v
`timescale 1ns/10ps
`include "purs_defines.vh"
// Contract
// - rising supply detector crossing produces an internal power-on reset pulse.
// - after power-on, delay timer and oscillator settle timer hold reset per configuration.
// - external reset pin acts only when its select bit is one.
// - power-up delay runs only for power-up type resets.
// - on power-on, the delay timer starts with the power-on pulse.
// - on low-supply reset, the delay starts when supply recovers.
// - delay timer counts internal rc oscillator cycles, not main oscillator.
// - device stays in reset while the delay timer is active.
// - configuration bit enables the delay timer for power-on only.
// - after low-supply reset the delay timer always runs.
// - settle timer follows the delay and counts 1024 main oscillator cycles.
// - settle timer runs only in crystal modes, on power-up or wake-up.
// - supply dip during delay re-enters low-supply reset and restarts timer.
// - delay timer configuration bit is active low.
module purs_sequencer #(
   parameter [15:0] DELAY_CYCLES = `PURS_DELAY_CYCLES
) (
   input wire mclk_in,
   input wire reset_in,
   input wire supply_rise_in,
   input wire low_supply_in,
   input wire low_supply_reset_en_in,
   input wire external_reset_pin_n_in,
   input wire external_reset_pin_select_in,
   input wire power_up_delay_timer_en_n_in,
   input wire [1:0] osc_mode_in,
   input wire wake_up_in,
   input wire rc_osc_in,
   input wire main_oscillator_input_in,
   output wire device_reset_out,
   output reg por_pulse_out,
   output reg delay_active_out,
   output reg settle_active_out,
   output reg low_supply_reset_out
);
   // sequencer states
   localparam [1:0] ST_HOLD = 2'h0;
   localparam [1:0] ST_DELAY = 2'h1;
   localparam [1:0] ST_SETTLE = 2'h2;
   localparam [1:0] ST_RUN = 2'h3;
   // counter constants
   localparam [`PURS_CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam [`PURS_CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam [`PURS_CNT_W-1:0] DELAY_LAST = DELAY_CYCLES - CNT_ONE;
   localparam [`PURS_CNT_W-1:0] SETTLE_LAST = `PURS_SETTLE_CYCLES - CNT_ONE;
   // synchroniser channels: rise, low, pin, rc, main oscillator
   localparam [4:0] SYNC_IDLE = 5'h04;

   // raw and synchronised pin levels
   wire [4:0] raw_w;
   wire [4:0] sync_w;
   wire rise_s;
   wire low_s;
   wire pin_n_s;
   wire rc_s;
   wire osc_s;

   // one-cycle enables from the slow clocks
   wire rc_tick;
   wire osc_tick;

   // decoded conditions
   wire por_evt;
   wire low_now;
   wire pin_rst;
   wire crystal;
   wire delay_en;
   wire delay_done;
   wire settle_done;

   // state and counters
   reg rise_prev_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [`PURS_CNT_W-1:0] delay_cnt_q;
   reg [`PURS_CNT_W-1:0] delay_cnt_d;
   reg [`PURS_CNT_W-1:0] settle_cnt_q;
   reg [`PURS_CNT_W-1:0] settle_cnt_d;
   reg settle_req_q;
   reg settle_req_d;

   assign raw_w[0] = supply_rise_in;
   assign raw_w[1] = low_supply_in;
   assign raw_w[2] = external_reset_pin_n_in;
   assign raw_w[3] = rc_osc_in;
   assign raw_w[4] = main_oscillator_input_in;

   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : g_sync
         purs_sync #(
            .RST_VAL(SYNC_IDLE[g])
         ) u_sync (
            .mclk_in(mclk_in),
            .reset_in(reset_in),
            .d_in(raw_w[g]),
            .q_out(sync_w[g])
         );
      end
   endgenerate

   assign rise_s = sync_w[0];
   assign low_s = sync_w[1];
   assign pin_n_s = sync_w[2];
   assign rc_s = sync_w[3];
   assign osc_s = sync_w[4];

   // delay timer counts internal rc edges only
   purs_edge u_rc_edge (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .lvl_in(rc_s),
      .tick_out(rc_tick)
   );

   // settle timer counts main oscillator edges
   purs_edge u_osc_edge (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .lvl_in(osc_s),
      .tick_out(osc_tick)
   );

   // power-on pulse on the rising supply crossing
   assign por_evt = rise_s & ~rise_prev_q;
   assign low_now = low_supply_reset_en_in & low_s;
   assign pin_rst = external_reset_pin_select_in & ~pin_n_s;
   assign crystal = (osc_mode_in == `PURS_OSC_LOW_POWER) |
      (osc_mode_in == `PURS_OSC_MEDIUM) |
      (osc_mode_in == `PURS_OSC_HIGH_SPEED);
   // cleared bit enables the delay, for power-on only
   assign delay_en = ~power_up_delay_timer_en_n_in;
   assign delay_done = (state_q == ST_DELAY) & rc_tick & (delay_cnt_q == DELAY_LAST);
   assign settle_done = (state_q == ST_SETTLE) & osc_tick & (settle_cnt_q == SETTLE_LAST);

   // hold reset through every phase except run; pin and low supply act at once
   assign device_reset_out = (state_q != ST_RUN) | low_now | pin_rst;

   // next state; power-on wins over low supply in the same cycle
   always @* begin
      state_d = state_q;
      if (por_evt) begin
         if (delay_en) begin
            state_d = ST_DELAY;
         end else if (crystal) begin
            state_d = ST_SETTLE;
         end else begin
            state_d = ST_RUN;
         end
      end else if (low_now) begin
         state_d = ST_HOLD;
      end else begin
         case (state_q)
            ST_HOLD: begin
               // low supply ended: delay always runs whatever the bit
               state_d = ST_DELAY;
            end
            ST_DELAY: begin
               if (delay_done) begin
                  state_d = settle_req_q ? ST_SETTLE : ST_RUN;
               end
            end
            ST_SETTLE: begin
               if (settle_done) begin
                  state_d = ST_RUN;
               end
            end
            ST_RUN: begin
               if (wake_up_in && crystal) begin
                  state_d = ST_SETTLE;
               end
            end
            default: begin
               state_d = ST_HOLD;
            end
         endcase
      end
   end

   // delay counter restarts on every entry and on a new power-on
   always @* begin
      delay_cnt_d = delay_cnt_q;
      if (por_evt || (state_q != ST_DELAY) || (state_d != ST_DELAY)) begin
         delay_cnt_d = CNT_ZERO;
      end else if (rc_tick) begin
         delay_cnt_d = delay_cnt_q + CNT_ONE;
      end
   end

   // settle counter restarts on every entry and on a new power-on
   always @* begin
      settle_cnt_d = settle_cnt_q;
      if (por_evt || (state_q != ST_SETTLE) || (state_d != ST_SETTLE)) begin
         settle_cnt_d = CNT_ZERO;
      end else if (osc_tick) begin
         settle_cnt_d = settle_cnt_q + CNT_ONE;
      end
   end

   // remembers whether the settle phase follows the delay
   always @* begin
      settle_req_d = settle_req_q;
      if (por_evt || low_now) begin
         settle_req_d = crystal;
      end else if (settle_done) begin
         settle_req_d = 1'b0;
      end
   end

   // state register
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         state_q <= ST_HOLD;
      end else begin
         state_q <= state_d;
      end
   end

   // counters and settle request
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         delay_cnt_q <= CNT_ZERO;
         settle_cnt_q <= CNT_ZERO;
         settle_req_q <= 1'b0;
      end else begin
         delay_cnt_q <= delay_cnt_d;
         settle_cnt_q <= settle_cnt_d;
         settle_req_q <= settle_req_d;
      end
   end

   // supply rise edge detector
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         rise_prev_q <= 1'b0;
      end else begin
         rise_prev_q <= rise_s;
      end
   end

   // registered status outputs
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         por_pulse_out <= 1'b0;
         delay_active_out <= 1'b0;
         settle_active_out <= 1'b0;
         low_supply_reset_out <= 1'b0;
      end else begin
         por_pulse_out <= por_evt;
         delay_active_out <= (state_d == ST_DELAY);
         settle_active_out <= (state_d == ST_SETTLE);
         low_supply_reset_out <= low_now;
      end
   end
endmodule // purs_sequencer

// File: rtl/purs_sync.v
`timescale 1ns/10ps
`include "purs_defines.vh"
// three-stage pin synchroniser; output changes when stages two and three agree
module purs_sync #(
   parameter [0:0] RST_VAL = 1'b0
) (
   input wire mclk_in,
   input wire reset_in,
   input wire d_in,
   output reg q_out
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         // stages start at the pin's idle level so no false change follows reset
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         s1_q <= d_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            q_out <= s3_q;
         end
      end
   end
endmodule // purs_sync

// File: tb/power_up_reset_sequencer_tb.sv
`timescale 1ns/10ps
module power_up_reset_sequencer_tb;
   logic mclk_in = 1'b0, rst = 1'b1, lse = 1'b1, pin_n = 1'b1, sel = 1'b0, en_n = 1'b0, wake = 1'b0;
   logic [1:0] mode = 2'h3;
   wire rise, low, rc, osc, dr, por, pa, oa, lsr;
   int n_fail = 0, n_checks = 0;
   logic [4:0] rows [6] = '{5'h03, 5'h07, 5'h0b, 5'h0e, 5'h1c, 5'h15};
   purs_supply_model pm (.mclk_in(mclk_in), .rise_out(rise), .low_out(low), .rc_out(rc), .osc_out(osc));
   purs_sequencer #(.DELAY_CYCLES(16'h0004)) dut (.mclk_in(mclk_in), .reset_in(rst), .supply_rise_in(rise),
      .low_supply_in(low), .low_supply_reset_en_in(lse), .external_reset_pin_n_in(pin_n), .wake_up_in(wake),
      .external_reset_pin_select_in(sel), .power_up_delay_timer_en_n_in(en_n), .osc_mode_in(mode),
      .rc_osc_in(rc), .main_oscillator_input_in(osc), .device_reset_out(dr), .por_pulse_out(por),
      .delay_active_out(pa), .settle_active_out(oa), .low_supply_reset_out(lsr));
   task chk(input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %0t got %0h exp %0h", $time, s, e);
      end
   endtask
   task complete_run;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic settle(input logic [4:0] r, input int p);
      int nr = 0, no = 0, np = 0;
      logic rp = rc, op = osc;
      for (int i = 0; i < 20000 && (i < 8 || dr); i++) begin
         @(posedge mclk_in) #1 nr += pa && rc && !rp;
         no += oa && osc && !op;
         np += por;
         {rp, op} = {rc, osc};
      end
      chk(dr, 1'b0);
      chk(nr inside {[3:5]}, r[1]);
      chk(no inside {[1023:1025]}, r[0]);
      chk(np, p);
   endtask
   task dip(input logic [1:0] e);
      pm.set_low(1'b1);
      repeat (20) @(posedge mclk_in);
      #1 chk({lsr, dr}, e);
      pm.set_low(1'b0);
   endtask
   initial forever #10 mclk_in = ~mclk_in;
   initial begin
      #1500000 n_fail++;
      complete_run;
   end
   initial begin
      repeat (2) @(posedge mclk_in);
      #1 chk({dr, por, pa, oa, lsr}, 5'h10);
      @(posedge mclk_in) rst <= 1'b0;
      settle(5'h0e, 0);
      foreach (rows[k]) begin
         @(posedge mclk_in) {en_n, mode} <= rows[k][4:2];
         pm.power_on();
         settle(rows[k], 1);
      end
      @(posedge mclk_in) wake <= 1'b1;
      @(posedge mclk_in) wake <= 1'b0;
      settle(5'h01, 0);
      @(posedge mclk_in) mode <= 2'h3;
      dip(2'h3);
      settle(5'h1e, 0);
      dip(2'h3);
      repeat (20) @(posedge mclk_in);
      dip(2'h3);
      settle(5'h1e, 0);
      @(posedge mclk_in) lse <= 1'b0;
      dip(2'h0);
      @(posedge mclk_in) pin_n <= 1'b0;
      repeat (10) @(posedge mclk_in);
      #1 chk(dr, 1'b0);
      @(posedge mclk_in) {sel, pin_n} <= 2'h3;
      @(posedge mclk_in) {en_n, pin_n} <= 2'h0;
      repeat (10) @(posedge mclk_in);
      #1 chk(dr, 1'b1);
      @(posedge mclk_in) pin_n <= 1'b1;
      settle(5'h0c, 0);
      @(posedge mclk_in) rst <= 1'b1;
      #1 chk({dr, por, pa, oa, lsr}, 5'h10);
      @(posedge mclk_in) rst <= 1'b0;
      settle(5'h0e, 1);
      complete_run;
   end
endmodule // power_up_reset_sequencer_tb

// File: tb/purs_monitor.sv
`timescale 1ns/10ps
module purs_monitor (
   input wire mclk_in,
   input wire reset_in,
   input wire device_reset_out,
   input wire por_pulse_out,
   input wire delay_active_out,
   input wire settle_active_out,
   input wire low_supply_reset_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   sequence s_low_end; $fell(low_supply_reset_out); endsequence
   property p_one; por_pulse_out |=> !por_pulse_out; endproperty
   a_one: assert property (p_one) else $error("long pulse");
   property p_hold; delay_active_out |-> device_reset_out; endproperty
   a_hold: assert property (p_hold) else $error("delay not held");
   property p_ost; settle_active_out |-> device_reset_out; endproperty
   a_ost: assert property (p_ost) else $error("settle not held");
   property p_excl; !(delay_active_out && settle_active_out); endproperty
   a_excl: assert property (p_excl) else $error("overlap");
   property p_low; low_supply_reset_out |-> device_reset_out && !delay_active_out; endproperty
   a_low: assert property (p_low) else $error("low supply");
   property p_len; $rose(delay_active_out) |-> delay_active_out [*8]; endproperty
   a_len: assert property (p_len) else $error("short delay");
   property p_after; s_low_end |-> ##[0:4] delay_active_out; endproperty
   a_after: assert property (p_after) else $error("no delay");
   property p_done; $fell(settle_active_out) && !low_supply_reset_out && !por_pulse_out |-> !device_reset_out;
   endproperty
   a_done: assert property (p_done) else $error("no release");
endmodule // purs_monitor
bind purs_sequencer purs_monitor mon (.*);

// File: tb/purs_supply_model.sv
`timescale 1ns/10ps
module purs_supply_model (
   input wire mclk_in,
   output reg rise_out = 1'b0,
   output reg low_out = 1'b0,
   output reg rc_out = 1'b0,
   output reg osc_out = 1'b0
);
   always #100 rc_out = ~rc_out;
   always #80 osc_out = ~osc_out;
   task power_on;
      @(posedge mclk_in) rise_out <= 1'b0;
      repeat (6) @(posedge mclk_in);
      rise_out <= 1'b1;
   endtask
   task set_low(input logic v);
      @(posedge mclk_in) low_out <= v;
   endtask
endmodule // purs_supply_model
